// file: common/ebm_pkg.sv
package ebm_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int GROUPS = 4;
  localparam int CMPS   = 8;
  localparam int STMTS  = 2;

  // ---------------------------------------------------------------
  // register map: group g window at g*0x40, word index in [5:2]
  // ---------------------------------------------------------------
  localparam logic [3:0]  IDX_ADDR_A_LO = 4'h0;
  localparam logic [3:0]  IDX_ADDR_A_HI = 4'h1;
  localparam logic [3:0]  IDX_ADDR_B_LO = 4'h2;
  localparam logic [3:0]  IDX_ADDR_B_HI = 4'h3;
  localparam logic [3:0]  IDX_ADDR_MODE = 4'h4;
  localparam logic [3:0]  IDX_DATA_A    = 4'h5;
  localparam logic [3:0]  IDX_DATA_B    = 4'h6;
  localparam logic [3:0]  IDX_STAT_A    = 4'h7;
  localparam logic [3:0]  IDX_STAT_B    = 4'h8;
  localparam logic [3:0]  IDX_PROBE     = 4'h9;
  localparam logic [3:0]  IDX_LIMIT     = 4'ha;
  localparam logic [3:0]  IDX_SPARE     = 4'hb;
  localparam logic [3:0]  IDX_STMT0     = 4'hc;
  localparam logic [11:0] CTRL_OFF      = 12'h100;
  localparam logic [11:0] STATUS_OFF    = 12'h104;
  localparam logic [11:0] ALIAS_OFF     = 12'h130;
  localparam int          CTRL_CLR_ALL  = 0;
  localparam int          CTRL_CLR_ONE  = 1;
  localparam int          CTRL_GRP_LSB  = 2;
  localparam logic [1:0]  FIRST_GROUP   = 2'h0;
  localparam logic [31:0] CFG_RESET     = 32'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] or_use;
    logic [7:0] inv;
    logic [7:0] and_use;
  } cond_t;

  typedef struct packed {
    logic        valid;
    logic [20:0] rsvd;
    logic [1:0]  next_group;
    logic        switch_grp;
    logic        reload;
    logic        brk;
    logic        count;
    logic        ext_trig;
    logic        trace_window;
    logic        trace_single;
    logic        trace_all;
  } action_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [15:0] data;
    logic [15:0] status;
    logic [15:0] probe;
  } bus_cycle_t;

  typedef struct packed {
    logic brk;
    logic count;
    logic ext_trig;
    logic trace_window;
    logic trace_single;
    logic trace_all;
  } action_out_t;
endpackage

// file: design/event_breakpoint_monitor.sv
`timescale 1ns/1ps
module event_breakpoint_monitor import ebm_pkg::*; #(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // axi4-lite slave
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic [2:0]   awprot,
  input  wire logic         wvalid,
  output logic              wready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  output logic              bvalid,
  input  wire logic         bready,
  output logic [1:0]        bresp,
  input  wire logic         arvalid,
  output logic              arready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic [2:0]   arprot,
  output logic              rvalid,
  input  wire logic         rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  // target side
  input  wire logic         run,
  input  wire bus_cycle_t   cycle,
  // actions and state
  output action_out_t       act,
  output logic [1:0]        active_group,
  output logic [15:0]       pass_counter
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0]   cfg_mem [0:63];
  logic          aw_full_reg, w_full_reg, run_reg;
  logic [AW-1:0] aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic          wr_go, wr_cfg, wr_ctrl, wr_ok;
  logic [5:0]    wr_slot;

  function automatic logic map_ok(input logic [AW-1:0] a);
    if (a[AW-1:9] != '0) begin
      return 1'b0;
    end else if (a[8]) begin
      return a[7:6] == 2'h0 && a[5:2] >= IDX_STMT0;
    end else begin
      return a[5:2] != IDX_SPARE;
    end
  endfunction

  // untagged statements land in group 1 through the alias window
  function automatic logic [5:0] map_slot(input logic [AW-1:0] a);
    return {a[8] ? FIRST_GROUP : a[7:6], a[5:2]};
  endfunction

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  assign awready = !aw_full_reg;
  assign wready  = !w_full_reg;
  assign wr_go   = aw_full_reg && w_full_reg && !bvalid;
  assign wr_slot = map_slot(aw_addr_reg);
  assign wr_cfg  = map_ok(aw_addr_reg);
  assign wr_ctrl = aw_addr_reg[11:2] == CTRL_OFF[11:2];
  // config is frozen while the target runs, so a refused write answers slverr
  assign wr_ok   = (wr_cfg || wr_ctrl) && !run;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // comparator and statement store, with clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        cfg_mem[i] <= CFG_RESET;
      end
    end else if (wr_go && wr_ok) begin
      if (wr_cfg) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) begin
            cfg_mem[wr_slot][8*b +: 8] <= w_data_reg[8*b +: 8];
          end
        end
      end else if (w_strb_reg[0]) begin
        for (int i = 0; i < 64; i++) begin
          if (i[3:0] >= IDX_STMT0 && (w_data_reg[CTRL_CLR_ALL] ||
              (w_data_reg[CTRL_CLR_ONE] &&
               i[5:4] == w_data_reg[CTRL_GRP_LSB +: 2]))) begin
            cfg_mem[i] <= CFG_RESET;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign arready = !rvalid;

  // full readback lets firmware copy all four group setups to nonvolatile store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      if (map_ok(araddr)) begin
        rdata <= cfg_mem[map_slot(araddr)];
      end else if (araddr[11:2] == STATUS_OFF[11:2]) begin
        rdata <= {pass_counter, 13'h0, run, active_group};
      end else begin
        rdata <= '0;
        if (araddr[11:2] != CTRL_OFF[11:2]) begin
          rresp <= RESP_SLVERR;
        end
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // comparators of the active group
  // ---------------------------------------------------------------
  logic [CMPS-1:0] match;
  logic [31:0]     mode_w;

  function automatic logic masked_hit(input logic [15:0] x, input logic [31:0] w);
    return ((x ^ w[15:0]) & ~w[31:16]) == 16'h0;
  endfunction

  function automatic logic addr_hit(input logic [23:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi, input logic [1:0] m);
    if (!m[0]) begin
      return a == lo[23:0];
    end else if (m[1]) begin
      return a <= lo[23:0] || a >= hi[23:0];
    end else begin
      return a >= lo[23:0] && a <= hi[23:0];
    end
  endfunction

  // everything is compared in parallel in the cycle itself, no stall
  assign mode_w = cfg_mem[{active_group, IDX_ADDR_MODE}];
  always_comb begin
    match[0] = addr_hit(cycle.addr, cfg_mem[{active_group, IDX_ADDR_A_LO}],
                        cfg_mem[{active_group, IDX_ADDR_A_HI}], mode_w[1:0]);
    match[1] = addr_hit(cycle.addr, cfg_mem[{active_group, IDX_ADDR_B_LO}],
                        cfg_mem[{active_group, IDX_ADDR_B_HI}], mode_w[3:2]);
    match[2] = masked_hit(cycle.data, cfg_mem[{active_group, IDX_DATA_A}]);
    match[3] = masked_hit(cycle.data, cfg_mem[{active_group, IDX_DATA_B}]);
    match[4] = masked_hit(cycle.status, cfg_mem[{active_group, IDX_STAT_A}]);
    match[5] = masked_hit(cycle.status, cfg_mem[{active_group, IDX_STAT_B}]);
    match[6] = masked_hit(cycle.probe, cfg_mem[{active_group, IDX_PROBE}]);
    match[7] = pass_counter == 16'h0;
  end

  // ---------------------------------------------------------------
  // statements
  // ---------------------------------------------------------------
  action_t    fired;
  logic       sw_hit;
  logic [1:0] sw_grp;

  always_comb begin
    cond_t   c;
    action_t a;
    logic [7:0] t;
    c      = '0;
    a      = '0;
    t      = '0;
    fired  = '0;
    sw_hit = 1'b0;
    sw_grp = active_group;
    for (int s = 0; s < STMTS; s++) begin
      c = cond_t'(cfg_mem[{active_group, IDX_STMT0 + 4'(2*s)}]);
      a = action_t'(cfg_mem[{active_group, IDX_STMT0 + 4'(2*s + 1)}]);
      t = match ^ c.inv;
      if (a.valid && run && cycle.valid &&
          ((c.and_use != 8'h0 && (t & c.and_use) == c.and_use) ||
           (t & c.or_use) != 8'h0)) begin
        fired = fired | a;
        if (a.switch_grp && !sw_hit) begin
          sw_hit = 1'b1;
          sw_grp = a.next_group;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // group, counter and action outputs
  // ---------------------------------------------------------------
  logic [15:0] limit_first, limit_next;
  assign limit_first = cfg_mem[{FIRST_GROUP, IDX_LIMIT}][15:0];
  assign limit_next  = cfg_mem[{sw_grp, IDX_LIMIT}][15:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_reg      <= 1'b0;
      active_group <= FIRST_GROUP;
    end else begin
      run_reg <= run;
      if (run && !run_reg) begin
        active_group <= FIRST_GROUP;
      end else if (sw_hit) begin
        active_group <= sw_grp;
      end
    end
  end

  // one counter shared by all groups; reload beats a count in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pass_counter <= '0;
    end else if (run && !run_reg) begin
      pass_counter <= limit_first;
    end else if (fired.reload) begin
      pass_counter <= limit_next;
    end else if (fired.count && pass_counter != 16'h0) begin
      pass_counter <= pass_counter - 16'h1;
    end
  end

  // actions leave as registered pulses, the target bus never waits on them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act <= '0;
    end else begin
      act <= '{brk: fired.brk, count: fired.count, ext_trig: fired.ext_trig,
               trace_window: fired.trace_window, trace_single: fired.trace_single,
               trace_all: fired.trace_all};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SWITCH_NEXT: assert property (sw_hit && !(run && !run_reg) |=>
    active_group == $past(sw_grp)) else $error("group switch not applied next cycle");
  AST_IDLE_STOPPED: assert property (!run |=> act == '0)
    else $error("action while target stopped");
  AST_RUN_LOAD: assert property (run && !run_reg |=>
    pass_counter == $past(limit_first) && active_group == FIRST_GROUP)
    else $error("run entry did not load group 1 limit");
  AST_BRK_FOLLOWS: assert property (fired.brk |=> act.brk)
    else $error("break not issued");
  AST_ACT_CAUSE: assert property (act != '0 |-> $past(run && cycle.valid))
    else $error("action without a bus cycle");
  AST_WRITE_REFUSED: assert property (wr_go && run |=>
    bvalid && bresp == RESP_SLVERR ##0 $stable(cfg_mem[0]))
    else $error("write accepted while running");
  AST_CLEAR_ALL: assert property (wr_go && wr_ok && wr_ctrl && w_strb_reg[0] &&
    w_data_reg[CTRL_CLR_ALL] |=> !cfg_mem[13][31] && !cfg_mem[15][31])
    else $error("statements survived clear");
  AST_COUNT_DOWN: assert property (fired.count && !fired.reload && !(run && !run_reg)
    && pass_counter != 16'h0 |=> pass_counter == $past(pass_counter) - 16'h1)
    else $error("pass counter did not step");
  AST_DONT_CARE: assert property (cfg_mem[{active_group, IDX_DATA_A}][31:16] == 16'hffff
    |-> match[2])
    else $error("masked data comparator missed");

  COV_SWITCH: cover property (sw_hit ##1 act != '0);
  COV_BREAK: cover property (run && !run_reg ##[1:50] act.brk);
  COV_RELOAD: cover property (fired.reload && fired.switch_grp);
endmodule

// file: verif/target_bus_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// target bus model
// ---------------------------------------------------------------
module target_bus_model import ebm_pkg::*; (
  // clock
  input  wire logic       clk,
  // bench requests
  input  wire logic       run_req,
  input  wire bus_cycle_t req,
  // target side
  output bus_cycle_t      cycle,
  output logic            run
);
  initial begin
    run   = 1'b0;
    cycle = '0;
  end
  // run follows the bench request one clock later
  always @(posedge clk) begin
    run <= run_req;
  end
  // one cycle per request, never stalled; idle lines show inverted data
  always @(posedge clk) begin
    if (run_req && req.valid) begin
      cycle <= req;
    end else begin
      cycle <= {1'b0, ~req[71:0]};
    end
  end
endmodule

// file: verif/event_breakpoint_monitor_test.sv
`timescale 1ns/1ps
module event_breakpoint_monitor_test import ebm_pkg::*;;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk = 0, rst = 1, run_req = 0, run;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  strb = 4'hf;
  logic [1:0]  bresp, rresp, active_group;
  logic [15:0] pass_counter;
  bus_cycle_t  req = '0, cycle;
  action_out_t act;
  logic [5:0]  exp_q[$];
  logic [23:0] a;
  logic        hit;
  int          n_fail = 0, checks_done = 0, seed = 11, ticks = 0, i, m;

  always #20 clk = ~clk;

  event_breakpoint_monitor #(.AW(12)) i_event_breakpoint_monitor (
    .clk(clk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .run(run), .cycle(cycle), .act(act),
    .active_group(active_group), .pass_counter(pass_counter)
  );

  target_bus_model i_target_bus_model (
    .clk(clk), .run_req(run_req), .req(req), .cycle(cycle), .run(run)
  );

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_act(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t act got=%h exp=%h", $time, got, exp);
    end
  endtask

  // any pulse takes the oldest note; a pulse with no note is wrong
  always @(negedge clk) begin
    if (!rst && act !== 6'h0) begin
      if (exp_q.size() == 0) check_act(act, 6'h0);
      else check_act(act, exp_q.pop_front());
    end
  end

  // hang guard, run takes a few hundred cycles
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  function automatic logic [11:0] ga(input logic [1:0] g, input logic [3:0] idx);
    return {4'h0, g, idx, 2'b00};
  endfunction

  // ready sampled at negedge so a comb drop at the taking edge is not missed
  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= ad; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    check_word({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    check_word(d, ed);
    check_word({30'h0, r}, {30'h0, er});
  endtask

  task automatic send(input logic [23:0] ad, input logic [15:0] d, input logic [5:0] e);
    @(posedge clk);
    req <= bus_cycle_t'{1'b1, ad, d, 16'($random(seed)), 16'($random(seed))};
    if (e != 6'h0) exp_q.push_back(e);
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic set_run(input logic v);
    @(posedge clk);
    run_req <= v;
    repeat (3) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    a = 24'($random(seed)) & 24'hfffff0;
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    rd(ga(2'h3, IDX_DATA_A), CFG_RESET, RESP_OKAY);
    rd(ga(2'h0, IDX_SPARE), 32'h0, RESP_SLVERR);
    wr(ga(2'h1, IDX_SPARE), 32'h1, RESP_SLVERR);
    wr(ga(2'h0, IDX_ADDR_A_LO), {8'h0, a}, RESP_OKAY);
    wr(ga(2'h0, IDX_DATA_A), 32'h00ff_1200, RESP_OKAY);
    wr(ga(2'h0, IDX_LIMIT), 32'h5, RESP_OKAY);
    wr(ALIAS_OFF, 32'h0000_0001, RESP_OKAY);
    wr(ALIAS_OFF + 12'h4, 32'h8000_0009, RESP_OKAY);
    rd(ga(2'h0, IDX_STMT0) + 12'h4, 32'h8000_0009, RESP_OKAY);
    wr(ga(2'h0, IDX_STMT0) + 12'h8, 32'h0004_0000, RESP_OKAY);
    wr(ga(2'h0, IDX_STMT0) + 12'hc, 32'h8000_01a0, RESP_OKAY);
    wr(ga(2'h1, IDX_DATA_A), 32'h0000_1234, RESP_OKAY);
    wr(ga(2'h1, IDX_STMT0), 32'h0004_0000, RESP_OKAY);
    wr(ga(2'h1, IDX_STMT0) + 12'h4, 32'h8000_0012, RESP_OKAY);
    set_run(1'b1);
    rd(STATUS_OFF, 32'h0005_0004, RESP_OKAY);
    check_word({pass_counter, 14'h0, active_group}, 32'h0005_0000);
    send(a, 16'h0000, 6'h09);
    send(a + 24'h1, 16'h1234, 6'h20);
    send(a, 16'h1234, 6'h12);
    send(a + 24'h1, 16'h1299, 6'h00);
    rd(STATUS_OFF, 32'h0004_0005, RESP_OKAY);
    check_word({pass_counter, 14'h0, active_group}, 32'h0004_0001);
    wr(ga(2'h0, IDX_DATA_B), 32'h1, RESP_SLVERR);
    set_run(1'b0);
    rd(ga(2'h0, IDX_DATA_B), CFG_RESET, RESP_OKAY);
    wr(CTRL_OFF, 32'h2, RESP_OKAY);
    rd(ga(2'h0, IDX_STMT0) + 12'h4, 32'h0, RESP_OKAY);
    rd(ga(2'h1, IDX_STMT0) + 12'h4, 32'h8000_0012, RESP_OKAY);
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    rd(ga(2'h1, IDX_STMT0) + 12'h4, 32'h0, RESP_OKAY);
    rd(ga(2'h0, IDX_DATA_A), 32'h00ff_1200, RESP_OKAY);
    // only the two low byte lanes may land
    strb <= 4'h3;
    wr(ga(2'h2, IDX_DATA_B), 32'hffff_abcd, RESP_OKAY);
    strb <= 4'hf;
    rd(ga(2'h2, IDX_DATA_B), 32'h0000_abcd, RESP_OKAY);
    wr(ga(2'h0, IDX_ADDR_A_LO), 32'h100, RESP_OKAY);
    wr(ga(2'h0, IDX_ADDR_A_HI), 32'h1ff, RESP_OKAY);
    wr(ga(2'h0, IDX_STMT0), 32'h1, RESP_OKAY);
    wr(ga(2'h0, IDX_STMT0) + 12'h4, 32'h8000_0004, RESP_OKAY);
    for (m = 1; m <= 3; m += 2) begin
      wr(ga(2'h0, IDX_ADDR_MODE), 32'(m), RESP_OKAY);
      set_run(1'b1);
      for (i = 0; i < 8; i++) begin
        a = 24'($unsigned($random(seed)) % 32'h300);
        if (i < 2) a = (i == 0) ? 24'h100 : 24'h1ff;
        hit = (m == 1) ? (a >= 24'h100 && a <= 24'h1ff) : (a <= 24'h100 || a >= 24'h1ff);
        send(a, 16'h0, hit ? 6'h04 : 6'h00);
      end
      set_run(1'b0);
    end
    repeat (5) @(posedge clk);
    check_word(32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule
